// ==== rtl/ccpd_channel.sv ====
/*
 * One capture/compare/pwm channel with its control and data registers,
 * reached as an AHB-Lite slave with zero wait states.
 * Assumes shared timers on i_clk: odd timers count 16 bits, even timers
 * give a 10-bit count (8-bit timer plus 2 fine bits) and a period pulse.
 */
`timescale 1ns/1ps
`include "ccpd_defines.svh"

module ccpd_channel
	import ccpd_pkg::*;
#(
	parameter int ODD_W  = 16,
	parameter int EVEN_W = 10
) (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	// ahb-lite slave
	input  wire logic              i_hsel,
	input  wire logic [31:0]       i_haddr,
	input  wire logic [1:0]        i_htrans,
	input  wire logic              i_hwrite,
	input  wire logic [2:0]        i_hsize,
	input  wire logic [31:0]       i_hwdata,
	input  wire logic              i_hready,
	output logic [31:0]            o_hrdata,
	output logic                   o_hreadyout,
	output logic                   o_hresp,
	// shared odd timers
	input  wire logic [ODD_W-1:0]  i_tmr1,
	input  wire logic [ODD_W-1:0]  i_tmr3,
	input  wire logic [ODD_W-1:0]  i_tmr5,
	input  wire logic [ODD_W-1:0]  i_tmr7,
	// shared even timers
	input  wire logic [EVEN_W-1:0] i_tmr2,
	input  wire logic [EVEN_W-1:0] i_tmr4,
	input  wire logic [EVEN_W-1:0] i_tmr6,
	input  wire logic [EVEN_W-1:0] i_tmr8,
	input  wire logic [3:0]        i_even_period,
	// channel pin
	input  wire logic              i_ccp_pin,
	output logic                   o_ccp_pin,
	output logic                   o_ccp_oe_n,
	// events
	output logic                   o_match,
	output logic                   o_capture,
	output logic                   o_timer_reset
);
	import ccpd_pkg::*;

	// registers
	logic [`CCPD_CTRL_W-1:0] ctrl_reg;
	logic [`CCPD_CTRL_W-1:0] ctrl_next;
	logic [7:0]              low_reg;
	logic [7:0]              low_next;
	logic [7:0]              high_reg;
	logic [7:0]              high_next;
	logic [`CCPD_TSEL_W-1:0] tsel_reg;
	logic [`CCPD_TSEL_W-1:0] tsel_next;
	logic [1:0]              fine_reg;
	logic [1:0]              fine_next;

	// output state
	logic                    pin_reg;
	logic                    pin_next;
	logic                    oe_n_reg;
	logic                    oe_n_next;
	logic                    match_reg;
	logic                    match_next;
	logic                    cap_reg;
	logic                    cap_next;
	logic                    trig_reg;
	logic                    trig_next;
	logic                    hit_reg;
	logic                    hit_next;

	// bus state
	logic                    wr_pend_reg;
	logic                    wr_pend_next;
	logic [7:0]              addr_reg;
	logic [7:0]              addr_next;
	logic [31:0]             rdata_reg;
	logic [31:0]             rdata_next;

	// internal
	ccpd_mode_t              mode;
	ccpd_class_t             cls;
	logic [ODD_W-1:0]        odd_tb;
	logic [EVEN_W-1:0]       even_tb;
	logic                    period;
	logic                    pin_sync;
	logic                    capture;
	logic                    take;
	logic [7:0]              raddr;
	logic [9:0]              duty;
	logic                    cmp_eq;
	logic [7:0]              ctrl_fwd;
	logic [7:0]              tsel_fwd;

	assign mode = ctrl_reg[`CCPD_MODE_MSB:`CCPD_MODE_LSB];
	assign cls  = ccpd_class(mode);

	ccpd_timer_sel #(
		.ODD_W  (ODD_W),
		.EVEN_W (EVEN_W)
	) u_tsel (
		.i_sel         (tsel_reg),
		.i_tmr1        (i_tmr1),
		.i_tmr3        (i_tmr3),
		.i_tmr5        (i_tmr5),
		.i_tmr7        (i_tmr7),
		.i_tmr2        (i_tmr2),
		.i_tmr4        (i_tmr4),
		.i_tmr6        (i_tmr6),
		.i_tmr8        (i_tmr8),
		.i_even_period (i_even_period),
		.o_odd         (odd_tb),
		.o_even        (even_tb),
		.o_period      (period)
	);

	ccpd_edge_det u_edge (
		.i_clk      (i_clk),
		.i_arst_n   (i_arst_n),
		.i_mode     (mode),
		.i_pin      (i_ccp_pin),
		.o_pin_sync (pin_sync),
		.o_capture  (capture)
	);

	// ---- bus: address phase taken, data phase applied next cycle ----
	assign take  = i_hsel & i_hready & i_htrans[1];
	assign raddr = {i_haddr[7:2], 2'b00};

	// read mux with forwarding of a write still in its data phase
	function automatic logic [7:0] fwd_byte(input logic [7:0] a, input logic [7:0] cur);
		logic [7:0] v;
		v = cur;
		if (wr_pend_reg && addr_reg == a) begin
			v = i_hwdata[7:0];
		end
		return v;
	endfunction : fwd_byte

	// narrow registers are widened to a byte so one forwarding path serves all
	assign ctrl_fwd = fwd_byte(`CCPD_OFS_CTRL, {2'b00, ctrl_reg});
	assign tsel_fwd = fwd_byte(`CCPD_OFS_TSEL, {6'h00, tsel_reg});

	always_comb begin
		wr_pend_next = take & i_hwrite;
		addr_next    = take ? raddr : addr_reg;
		rdata_next   = 32'h0000_0000;
		if (take && !i_hwrite) begin
			unique case (raddr)
				`CCPD_OFS_CTRL: begin
					rdata_next[`CCPD_CTRL_W-1:0] = ctrl_fwd[`CCPD_CTRL_W-1:0];
				end
				`CCPD_OFS_LOW:  rdata_next[7:0] = fwd_byte(`CCPD_OFS_LOW, low_reg);
				`CCPD_OFS_HIGH: rdata_next[7:0] = fwd_byte(`CCPD_OFS_HIGH, high_reg);
				`CCPD_OFS_TSEL: begin
					rdata_next[`CCPD_TSEL_W-1:0] = tsel_fwd[`CCPD_TSEL_W-1:0];
				end
				`CCPD_OFS_STATUS: rdata_next[5:0] = {pin_sync, pin_reg, ~oe_n_reg, 3'(cls)};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			rdata_reg   <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= wr_pend_next;
			addr_reg    <= addr_next;
			rdata_reg   <= rdata_next;
		end
	end

	// ---- channel registers ----
	assign duty   = {high_reg, fine_reg};
	assign cmp_eq = (odd_tb == {high_reg, low_reg});

	always_comb begin
		ctrl_next = ctrl_reg;
		low_next  = low_reg;
		high_next = high_reg;
		tsel_next = tsel_reg;
		fine_next = fine_reg;
		// software writes first; a capture in the same cycle overrides them
		if (wr_pend_reg) begin
			unique case (addr_reg)
				`CCPD_OFS_CTRL: ctrl_next = i_hwdata[`CCPD_CTRL_W-1:0];
				`CCPD_OFS_LOW:  low_next  = i_hwdata[7:0];
				`CCPD_OFS_HIGH: high_next = i_hwdata[7:0];
				`CCPD_OFS_TSEL: tsel_next = i_hwdata[`CCPD_TSEL_W-1:0];
				default: ;
			endcase
		end
		if (cls == CCPD_CLS_CAPTURE && capture) begin
			high_next = odd_tb[15:8];
			low_next  = odd_tb[7:0];
		end
		// pwm: duty buffer reloads from the written value at each period
		if (cls == CCPD_CLS_PWM && period) begin
			high_next = low_reg;
			fine_next = ctrl_reg[`CCPD_DUTY_MSB:`CCPD_DUTY_LSB];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_reg <= `CCPD_RST_CTRL;
			low_reg  <= `CCPD_RST_BYTE;
			high_reg <= `CCPD_RST_BYTE;
			tsel_reg <= `CCPD_RST_TSEL;
			fine_reg <= 2'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			low_reg  <= low_next;
			high_reg <= high_next;
			tsel_reg <= tsel_next;
			fine_reg <= fine_next;
		end
	end

	// ---- pin and event generation ----
	always_comb begin
		pin_next   = pin_reg;
		oe_n_next  = 1'b1;
		match_next = 1'b0;
		cap_next   = 1'b0;
		trig_next  = 1'b0;
		// one action per match: the odd timer may sit on the value for many cycles
		hit_next   = cmp_eq;
		unique case (cls)
			CCPD_CLS_OFF: begin
				pin_next = 1'b0;
				hit_next = 1'b0;
			end
			CCPD_CLS_CAPTURE: begin
				cap_next = capture;
			end
			CCPD_CLS_COMPARE: begin
				if (mode != `CCPD_M_SOFT) begin
					oe_n_next = 1'b0;
				end
				if (cmp_eq && !hit_reg) begin
					match_next = 1'b1;
					unique case (mode)
						`CCPD_M_TOGGLE: pin_next  = ~pin_reg;
						`CCPD_M_SET_HI: pin_next  = 1'b1;
						`CCPD_M_SET_LO: pin_next  = 1'b0;
						`CCPD_M_TRIG:   trig_next = 1'b1;
						default: ;
					endcase
				end
			end
			CCPD_CLS_PWM: begin
				oe_n_next = 1'b0;
				hit_next  = 1'b0;
				// high at period start unless duty is zero, low once count reaches duty
				if (period) begin
					pin_next = (low_reg != 8'h00) ||
						(ctrl_reg[`CCPD_DUTY_MSB:`CCPD_DUTY_LSB] != 2'h0);
				end else if (even_tb >= duty) begin
					pin_next = 1'b0;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_reg   <= 1'b0;
			oe_n_reg  <= 1'b1;
			match_reg <= 1'b0;
			cap_reg   <= 1'b0;
			trig_reg  <= 1'b0;
			hit_reg   <= 1'b0;
		end else begin
			pin_reg   <= pin_next;
			oe_n_reg  <= oe_n_next;
			match_reg <= match_next;
			cap_reg   <= cap_next;
			trig_reg  <= trig_next;
			hit_reg   <= hit_next;
		end
	end

	// a write to mode code 1000 or 1001 does not initialise the pin level
	// (handled via ctrl change: preset on entry is left to software writing
	// the mode before the timer reaches the compare value)

	assign o_hrdata      = rdata_reg;
	assign o_hreadyout   = 1'b1;
	assign o_hresp       = 1'b0;
	assign o_ccp_pin     = pin_reg;
	assign o_ccp_oe_n    = oe_n_reg;
	assign o_match       = match_reg;
	assign o_capture     = cap_reg;
	assign o_timer_reset = trig_reg;

endmodule : ccpd_channel

// ==== rtl/ccpd_defines.svh ====
/*
 * Constants for one capture/compare/pwm channel: register byte offsets,
 * field positions, reset values and counts.
 * Assumes inclusion by bare name from the package and ccpd_channel.
 */
`ifndef CCPD_DEFINES_SVH
`define CCPD_DEFINES_SVH

// register byte offsets
`define CCPD_OFS_CTRL     8'h00
`define CCPD_OFS_LOW      8'h04
`define CCPD_OFS_HIGH     8'h08
`define CCPD_OFS_TSEL     8'h0c
`define CCPD_OFS_STATUS   8'h10

// control register fields
`define CCPD_MODE_MSB     3
`define CCPD_MODE_LSB     0
`define CCPD_DUTY_MSB     5
`define CCPD_DUTY_LSB     4
`define CCPD_CTRL_W       6

// timer select field
`define CCPD_TSEL_W       2

// reset values
`define CCPD_RST_CTRL     6'h00
`define CCPD_RST_BYTE     8'h00
`define CCPD_RST_TSEL     2'h0

// capture prescale terminal counts
`define CCPD_PRE4_LAST    4'h3
`define CCPD_PRE16_LAST   4'hf

// mode codes
`define CCPD_M_OFF        4'h0
`define CCPD_M_TOGGLE     4'h2
`define CCPD_M_FALL       4'h4
`define CCPD_M_RISE       4'h5
`define CCPD_M_RISE4      4'h6
`define CCPD_M_RISE16     4'h7
`define CCPD_M_SET_HI     4'h8
`define CCPD_M_SET_LO     4'h9
`define CCPD_M_SOFT       4'ha
`define CCPD_M_TRIG       4'hb

`endif

// ==== rtl/ccpd_pkg.sv ====
/*
 * Types and the shared mode decode of the channel.
 * Assumes the constants header is on the include path.
 */
`include "ccpd_defines.svh"

package ccpd_pkg;

	typedef enum logic [2:0] {
		CCPD_CLS_OFF,
		CCPD_CLS_CAPTURE,
		CCPD_CLS_COMPARE,
		CCPD_CLS_PWM,
		CCPD_CLS_RESERVED
	} ccpd_class_t;

	typedef logic [3:0] ccpd_mode_t;

	// mode field to function class, used by the top; the edge detector decodes i_mode itself
	function automatic ccpd_class_t ccpd_class(input ccpd_mode_t mode);
		ccpd_class_t cls;
		cls = CCPD_CLS_RESERVED;
		if (mode == `CCPD_M_OFF) begin
			cls = CCPD_CLS_OFF;
		end else if (mode[3:2] == 2'h1) begin
			cls = CCPD_CLS_CAPTURE;
		end else if (mode[3:2] == 2'h3) begin
			cls = CCPD_CLS_PWM;
		end else if (mode[3:2] == 2'h2 || mode == `CCPD_M_TOGGLE) begin
			cls = CCPD_CLS_COMPARE;
		end
		return cls;
	endfunction : ccpd_class

endpackage : ccpd_pkg

// ==== rtl/ccpd_edge_det.sv ====
/*
 * Capture event detector: synchronises the channel pin and produces one
 * capture pulse per selected edge, with the 4th and 16th edge prescalers.
 * Assumes i_pin is asynchronous to i_clk.
 */
`timescale 1ns/1ps

module ccpd_edge_det
	import ccpd_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	// control
	input  wire ccpd_pkg::ccpd_mode_t i_mode,
	// pin and result
	input  wire logic              i_pin,
	output logic                   o_pin_sync,
	output logic                   o_capture
);
	import ccpd_pkg::*;

	logic [2:0] sync_reg;
	logic [2:0] sync_next;
	logic       level_reg;
	logic       level_next;
	logic [3:0] pre_reg;
	logic [3:0] pre_next;
	ccpd_mode_t mode_reg;
	logic       rise;
	logic       fall;

	always_comb begin
		sync_next  = {sync_reg[1:0], i_pin};
		level_next = level_reg;
		// a change counts only once the second and third stages agree
		if (sync_reg[1] == sync_reg[2]) begin
			level_next = sync_reg[2];
		end
		rise = level_next & ~level_reg;
		fall = ~level_next & level_reg;
		pre_next  = pre_reg;
		o_capture = 1'b0;
		unique case (i_mode)
			`CCPD_M_FALL: o_capture = fall;
			`CCPD_M_RISE: o_capture = rise;
			`CCPD_M_RISE4: begin
				if (rise) begin
					o_capture = ({2'b00, pre_reg[1:0]} == `CCPD_PRE4_LAST);
					pre_next  = pre_reg + 4'h1;
				end
			end
			`CCPD_M_RISE16: begin
				if (rise) begin
					o_capture = (pre_reg == `CCPD_PRE16_LAST);
					pre_next  = pre_reg + 4'h1;
				end
			end
			default: pre_next = 4'h0;
		endcase
		// a new mode starts its prescale count afresh
		if (i_mode != mode_reg) begin
			pre_next = 4'h0;
		end
		o_pin_sync = level_reg;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_reg  <= 3'h0;
			level_reg <= 1'b0;
			pre_reg   <= 4'h0;
			mode_reg  <= `CCPD_M_OFF;
		end else begin
			sync_reg  <= sync_next;
			level_reg <= level_next;
			pre_reg   <= pre_next;
			mode_reg  <= i_mode;
		end
	end

endmodule : ccpd_edge_det

// ==== rtl/ccpd_timer_sel.sv ====
/*
 * Time base selection: the odd timer family feeds capture and compare,
 * the even family feeds pwm, one shared select index picks the member.
 * Assumes the timers run on i_clk.
 */
`timescale 1ns/1ps

module ccpd_timer_sel #(
	parameter int ODD_W  = 16,
	parameter int EVEN_W = 10
) (
	// selection
	input  wire logic [1:0]        i_sel,
	// odd timers one, three, five, seven
	input  wire logic [ODD_W-1:0]  i_tmr1,
	input  wire logic [ODD_W-1:0]  i_tmr3,
	input  wire logic [ODD_W-1:0]  i_tmr5,
	input  wire logic [ODD_W-1:0]  i_tmr7,
	// even timers two, four, six, eight with their period pulses
	input  wire logic [EVEN_W-1:0] i_tmr2,
	input  wire logic [EVEN_W-1:0] i_tmr4,
	input  wire logic [EVEN_W-1:0] i_tmr6,
	input  wire logic [EVEN_W-1:0] i_tmr8,
	input  wire logic [3:0]        i_even_period,
	// selected time bases
	output logic [ODD_W-1:0]       o_odd,
	output logic [EVEN_W-1:0]      o_even,
	output logic                   o_period
);

	always_comb begin
		unique case (i_sel)
			2'h0: begin
				o_odd  = i_tmr1;
				o_even = i_tmr2;
			end
			2'h1: begin
				o_odd  = i_tmr3;
				o_even = i_tmr4;
			end
			2'h2: begin
				o_odd  = i_tmr5;
				o_even = i_tmr6;
			end
			2'h3: begin
				o_odd  = i_tmr7;
				o_even = i_tmr8;
			end
		endcase
		o_period = i_even_period[i_sel];
	end

endmodule : ccpd_timer_sel

// ==== tb/ccpd_monitor.sv ====
/* ccpd_monitor: port relations of ccpd_channel.
 * assumes it is bound into ccpd_channel; one clock domain. */
`timescale 1ns/1ps
module ccpd_monitor #(
	parameter int ODD_W  = 16,
	parameter int EVEN_W = 10
) (
	input wire logic             i_clk,
	input wire logic             i_arst_n,
	// bus
	input wire logic             i_hsel,
	input wire logic [31:0]      i_haddr,
	input wire logic [1:0]       i_htrans,
	input wire logic             i_hwrite,
	input wire logic [31:0]      i_hwdata,
	input wire logic             i_hready,
	input wire logic [31:0]      o_hrdata,
	input wire logic             o_hreadyout,
	input wire logic             o_hresp,
	// odd timers
	input wire logic [ODD_W-1:0] i_tmr1,
	input wire logic [ODD_W-1:0] i_tmr3,
	input wire logic [ODD_W-1:0] i_tmr5,
	input wire logic [ODD_W-1:0] i_tmr7,
	// pin and events
	input wire logic             o_ccp_pin,
	input wire logic             o_ccp_oe_n,
	input wire logic             o_match,
	input wire logic             o_capture
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// shadow of what software wrote; captures are not tracked, so compare checks need fresh writes
	logic             dp_reg, wr_reg, drv;
	logic [7:0]       ad_reg, lo_reg, hi_reg;
	logic [3:0]       md_reg;
	logic [1:0]       ts_reg;
	logic [ODD_W-1:0] sel;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dp_reg <= 1'b0;
			wr_reg <= 1'b0;
			ad_reg <= 8'h00;
			lo_reg <= 8'h00;
			hi_reg <= 8'h00;
			md_reg <= 4'h0;
			ts_reg <= 2'h0;
		end else begin
			dp_reg <= i_hsel & i_hready & i_htrans[1];
			wr_reg <= i_hwrite;
			ad_reg <= i_haddr[7:0];
			if (dp_reg && wr_reg && ad_reg == 8'h00) md_reg <= i_hwdata[3:0];
			if (dp_reg && wr_reg && ad_reg == 8'h04) lo_reg <= i_hwdata[7:0];
			if (dp_reg && wr_reg && ad_reg == 8'h08) hi_reg <= i_hwdata[7:0];
			if (dp_reg && wr_reg && ad_reg == 8'h0c) ts_reg <= i_hwdata[1:0];
		end
	end
	always_comb begin
		sel = (ts_reg == 2'h0) ? i_tmr1 : (ts_reg == 2'h1) ? i_tmr3 : (ts_reg == 2'h2) ? i_tmr5 : i_tmr7;
		drv = (md_reg[3:2] == 2'h3) || (md_reg[3:2] == 2'h2 && md_reg != 4'ha) || md_reg == 4'h2;
	end
	property p_bus; o_hreadyout && !o_hresp; endproperty
	a_bus: assert property (p_bus) else $error("bus not ready or not okay");
	property p_rd_idle; (!dp_reg || wr_reg) |-> o_hrdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read phase");
	property p_off; (md_reg == 4'h0) [*3] |-> o_ccp_oe_n && !o_ccp_pin; endproperty
	a_off: assert property (p_off) else $error("pin active while off");
	property p_drive; drv [*3] |-> !o_ccp_oe_n; endproperty
	a_drive: assert property (p_drive) else $error("pin not driven in output mode");
	property p_cap_in; (md_reg[3:2] == 2'h1) [*3] |-> o_ccp_oe_n; endproperty
	a_cap_in: assert property (p_cap_in) else $error("pin driven in capture");
	property p_cap_src; o_capture |-> $past(md_reg[3:2]) == 2'h1; endproperty
	a_cap_src: assert property (p_cap_src) else $error("capture outside capture mode");
	property p_cap_one; o_capture |=> !o_capture; endproperty
	a_cap_one: assert property (p_cap_one) else $error("capture pulse too long");
	property p_match; o_match |-> $past(sel) == {hi_reg, lo_reg} || $past(sel, 2) == {hi_reg, lo_reg}; endproperty
	a_match: assert property (p_match) else $error("match without equal timer");
	property p_match_one; o_match |=> !o_match; endproperty
	a_match_one: assert property (p_match_one) else $error("match pulse too long");
	c_match: cover property (o_match);
	c_cap: cover property (o_capture);
	c_pwm: cover property (md_reg[3:2] == 2'h3 && $rose(o_ccp_pin));
endmodule : ccpd_monitor

bind ccpd_channel ccpd_monitor #(.ODD_W(ODD_W), .EVEN_W(EVEN_W)) u_mon (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
	.i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_tmr1(i_tmr1), .i_tmr3(i_tmr3), .i_tmr5(i_tmr5),
	.i_tmr7(i_tmr7), .o_ccp_pin(o_ccp_pin), .o_ccp_oe_n(o_ccp_oe_n), .o_match(o_match), .o_capture(o_capture)
);

// ==== tb/ccpd_timer_model.sv ====
/* ccpd_timer_model: the shared timers seen by the channel.
 * assumes one clock; every timer pauses while i_run is low. */
`timescale 1ns/1ps
module ccpd_timer_model (
	// clock, reset, control
	input  wire logic   i_clk,
	input  wire logic   i_arst_n,
	input  wire logic   i_run,
	// odd family
	output logic [15:0] o_tmr1, o_tmr3, o_tmr5, o_tmr7,
	// even family and period pulses
	output logic [9:0]  o_tmr2, o_tmr4, o_tmr6, o_tmr8,
	output logic [3:0]  o_period
);
	logic [15:0] cnt_reg;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_reg <= 16'h0000;
		end else if (i_run) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
	// members a quarter turn apart, so only the selected one can hit a nearby value
	assign o_tmr1 = cnt_reg;
	assign o_tmr3 = cnt_reg + 16'h4000;
	assign o_tmr5 = cnt_reg + 16'h8000;
	assign o_tmr7 = cnt_reg + 16'hc000;
	assign o_tmr2 = cnt_reg[9:0];
	assign o_tmr4 = cnt_reg[9:0] + 10'h100;
	assign o_tmr6 = cnt_reg[9:0] + 10'h200;
	assign o_tmr8 = cnt_reg[9:0] + 10'h300;
	// no period pulse while stopped, as a halted timer never wraps
	assign o_period = {4{i_run}} & {o_tmr8 == 10'h3ff, o_tmr6 == 10'h3ff, o_tmr4 == 10'h3ff, o_tmr2 == 10'h3ff};
endmodule : ccpd_timer_model

// ==== tb/ccp_data_register_timer_map_bench.sv ====
/* ccp_data_register_timer_map_bench: self-checking bench of ccpd_channel.
 * assumes the timer model on the far side; registers modelled here. */
`timescale 1ns/1ps
module ccp_data_register_timer_map_bench;
	logic        i_clk, i_arst_n, hsel, hwrite, run, pin, rdy_q, hready, hresp, opin, oe_n, match, capt, treset;
	logic [31:0] haddr, hwdata, hrdata, rd_q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] t1, t3, t5, t7;
	logic [9:0]  t2, t4, t6, t8;
	logic [3:0]  per;
	int          failures, checks, ntr, ncap;
	integer      seed;
	int          m[0:15], msk[0:15];
	int          cm[4] = '{8, 2, 'hb, 9};
	int          ned[4] = '{1, 1, 4, 16};
	ccpd_timer_model tm (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_run(run), .o_tmr1(t1), .o_tmr3(t3), .o_tmr5(t5),
		.o_tmr7(t7), .o_tmr2(t2), .o_tmr4(t4), .o_tmr6(t6), .o_tmr8(t8), .o_period(per));
	ccpd_channel dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .i_tmr1(t1), .i_tmr3(t3), .i_tmr5(t5), .i_tmr7(t7),
		.i_tmr2(t2), .i_tmr4(t4), .i_tmr6(t6), .i_tmr8(t8), .i_even_period(per), .i_ccp_pin(pin),
		.o_ccp_pin(opin), .o_ccp_oe_n(oe_n), .o_match(match), .o_capture(capt), .o_timer_reset(treset));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// sampled at the edge so the bench reads pre-edge values without a race
	always @(posedge i_clk) begin
		rd_q <= hrdata;
		rdy_q <= hready;
		ntr <= ntr + int'(treset);
		ncap <= ncap + int'(capt);
	end
	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] e, input logic [31:0] g, input string s);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t %s: exp %h got %h", $time, s, e, g);
		end
	endtask : chk
	task automatic bail(input string s);
		failures++;
		$display("[FAIL] %0t wait for %s ran out", $time, s);
		finish_test();
	endtask : bail
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (rdy_q !== 1'b1 && n < 9);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (rdy_q !== 1'b1 && n < 19);
		r = rd_q;
		if (n >= 19) bail("bus");
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
		m[a[5:2]] = int'(d) & msk[a[5:2]];
	endtask : wr
	task automatic rd(input logic [7:0] a, input string s);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(32'(m[a[5:2]]), r, s);
	endtask : rd
	// waits for a compare match, or for the even timer of select 2 to reach v
	task automatic wt(input logic mt, input logic [9:0] v);
		int k;
		k = 0;
		while (!(mt ? match === 1'b1 : t6 === v) && k < 1100) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		if (k >= 1100) bail("event");
	endtask : wt
	function automatic logic [15:0] odd(input int s);
		return (s == 0) ? t1 : (s == 1) ? t3 : (s == 2) ? t5 : t7;
	endfunction : odd
	initial begin
		logic [7:0]  a;
		logic [31:0] d;
		logic [15:0] v;
		int          n;
		seed = 32'hffe3b052;
		failures = 0;
		checks = 0;
		ntr = 0;
		ncap = 0;
		{hsel, hwrite, haddr, hwdata, htrans, pin, i_arst_n} = '0;
		hsize = 3'h2;
		run = 1'b1;
		foreach (m[i]) begin
			m[i] = 0;
			msk[i] = 0;
		end
		msk[0] = 'h3f;
		msk[1] = 'hff;
		msk[2] = 'hff;
		msk[3] = 'h3;
		repeat (6) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		#1;
		for (int i = 0; i < 5; i++) rd(8'(4 * i), "reset value");
		rd(8'h20, "unmapped");
		for (int k = 0; k < 12; k++) begin
			a = 8'(4 * (k % 4));
			d = $random(seed);
			if (a == 8'h00) d = d & 32'h30;
			wr(a, d);
			rd(a, "readback");
		end
		wr(8'h20, $random(seed));
		rd(8'h20, "unmapped write");
		$display("test registers done");
		for (int s = 0; s < 4; s++) begin
			wr(8'h00, 32'h0);
			wr(8'h0c, s);
			v = odd(s) + 16'h0100;
			wr(8'h04, 32'(v[7:0]));
			wr(8'h08, 32'(v[15:8]));
			n = ntr;
			wr(8'h00, cm[s]);
			wt(1'b1, 10'h0);
			repeat (3) @(posedge i_clk);
			#1;
			if (cm[s] != 'hb) chk(32'(cm[s] != 9), 32'(opin), "pin after match");
			chk(32'(cm[s] == 'hb), 32'(ntr != n), "trigger pulse");
			rd(8'h08, "compare high");
			rd(8'h04, "compare low");
		end
		$display("test compare done");
		for (int s = 0; s < 4; s++) begin
			run <= 1'b1;
			wr(8'h00, 32'h0);
			wr(8'h0c, s);
			run <= 1'b0;
			wr(8'h00, 4 + s);
			v = odd(s);
			n = ncap;
			for (int k = 0; k < 2 * ned[s]; k++) begin
				pin <= ~pin;
				repeat (5) @(posedge i_clk);
			end
			repeat (8) @(posedge i_clk);
			#1;
			chk(1, ncap - n, "capture count");
			m[2] = v[15:8];
			m[1] = v[7:0];
			rd(8'h08, "capture high");
			rd(8'h04, "capture low");
		end
		$display("test capture done");
		run <= 1'b1;
		wr(8'h00, 32'h0);
		wr(8'h0c, 32'h2);
		wr(8'h08, 32'h11);
		wt(1'b0, 10'h100);
		wr(8'h04, 32'h40);
		wr(8'h00, 32'h3c);
		rd(8'h08, "duty buffer held");
		wt(1'b0, 10'h080);
		m[2] = m[1];
		rd(8'h08, "duty buffer loaded");
		wt(1'b0, 10'h102);
		chk(1, 32'(opin), "pwm high");
		wt(1'b0, 10'h108);
		chk(0, 32'(opin), "pwm low");
		wr(8'h00, 32'h0);
		repeat (3) @(posedge i_clk);
		#1;
		chk(1, 32'(oe_n), "off releases pin");
		$display("test pwm done");
		finish_test();
	end
endmodule : ccp_data_register_timer_map_bench
